/* File: rtl/tkr_consts.vh */
/*
  Constants of the touch key command responder: command codes, reply
  lengths, status layout and timing. Assumes inclusion by the .v files.
*/
`ifndef TKR_CONSTS_VH
`define TKR_CONSTS_VH

// ----------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------
`define TKR_CMD_NULL     8'h00
`define TKR_CMD_OVERVIEW 8'h06
`define TKR_CMD_KEYS     8'h07
`define TKR_CMD_ERRORS   8'h0B
`define TKR_CMD_DUMP     8'h0D
`define TKR_CMD_EECRC    8'h0E
`define TKR_CMD_LAST     8'h0F
`define TKR_CMD_DIAG_A   8'h10
`define TKR_CMD_DIAG_B   8'h13
`define TKR_CMD_SLEEP    8'h16
`define TKR_CLS_DATA     2'b01
`define TKR_CLS_STAT     2'b10
`define TKR_CLS_CAL      2'b11
`define TKR_KEY_MAX      6'h2F

// ----------------------------------------------------------------------
// Reply lengths in data bytes, CRC bytes excluded
// ----------------------------------------------------------------------
`define TKR_LEN_OVERVIEW 9'h005
`define TKR_LEN_FIELDS   9'h006
`define TKR_LEN_SETUPS   9'h15C
`define TKR_LEN_KDATA    9'h005
`define TKR_LEN_ONE      9'h001
`define TKR_LEN_NONE     9'h000

// ----------------------------------------------------------------------
// Misc values
// ----------------------------------------------------------------------
`define TKR_CRC_INIT     16'h0000
`define TKR_CRC_POLY     16'h1021
`define TKR_STAT_RSVD    3'h0
`define TKR_DIAG_CODE    8'h5A
`define TKR_TMO_MS       110
`define TKR_CLK_KHZ      200000
`define TKR_TMO_CYCLES   (`TKR_TMO_MS * `TKR_CLK_KHZ)

`endif

/* File: rtl/tkr_crc16.v */
/*
  Byte-wise CRC-16 accumulator for the reply stream.
  Assumes the caller presents one byte per feed pulse on the same clock.
*/
`timescale 1ns/1ps
`include "tkr_consts.vh"

module tkr_crc16 (
  // Clock and reset
  input  wire        clk,
  input  wire        reset_n,
  // Control
  input  wire        init,
  input  wire        feed,
  input  wire [7:0]  data,
  // Result
  output reg  [15:0] crc_reg
);

  // --------------------------------------------------------------------
  // Update function, MSB first
  // --------------------------------------------------------------------
  function [15:0] crc_upd;
    input [15:0] c;
    input [7:0]  d;
    integer i;
    reg [15:0] t;
    begin
      t = c ^ {d, 8'h00};
      for (i = 0; i < 8; i = i + 1) begin
        if (t[15])
          t = {t[14:0], 1'b0} ^ `TKR_CRC_POLY;
        else
          t = {t[14:0], 1'b0};
      end
      crc_upd = t;
    end
  endfunction

  // --------------------------------------------------------------------
  // Accumulator; init with feed seeds from the first byte
  // --------------------------------------------------------------------
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      crc_reg <= `TKR_CRC_INIT;
    else if (init && feed)
      crc_reg <= crc_upd(`TKR_CRC_INIT, data);
    else if (init)
      crc_reg <= `TKR_CRC_INIT;
    else if (feed)
      crc_reg <= crc_upd(crc_reg, data);
  end

endmodule

/* File: rtl/tkr_responder.v */
/*
  Host command responder of a matrix touch sensor: SPI slave link,
  command decode, reply sequencing with CRC, sleep and key calibration.
  Assumes sensor data, setups memory (one cycle read latency) and scan
  events come from logic on clk; link pins and wake come from outside.
*/
// Contract
// - Overview returns status, first key, tick, scan and fail counters, then CRC.
// - Key detect and error commands return six bit-field bytes plus CRC.
// - Reply CRC covers the command byte and all returned data bytes; dump and EEPROM CRC cover setups only.
// - Dump halts scanning, sends setups then CRC low first, then resumes.
// - UART mode dump aborts when a byte waits over 110 ms.
// - EEPROM CRC returns CRC over setups only, low byte first.
// - Last-command query returns complement of the previous byte, even invalid.
// - Diagnostic queries return an internal code plus CRC.
// - Sleep command is acked, then sleep at scan end if idle and enabled.
// - Asleep, wake input forces a scan; other valid command cancels sleep.
// - Key data returns signal, reference, integrator, low byte first, plus CRC.
// - Key status returns one byte with fixed bit layout plus CRC.
// - Calibration acked with complement when scheduled, runs in key timeslot.
`timescale 1ns/1ps
`include "tkr_consts.vh"

module tkr_responder #(
  parameter [24:0] TMO_CYCLES = `TKR_TMO_CYCLES
) (
  // Clock and reset
  input  wire        clk,
  input  wire        reset_n,
  // SPI link pins
  input  wire        spi_sck,
  input  wire        spi_mosi,
  input  wire        spi_ss_n,
  output reg         spi_miso_reg,
  output reg         data_ready_line_reg,
  // Mode and configuration
  input  wire        uart_mode,
  input  wire        sleep_enable,
  // Sensor state
  input  wire [7:0]  dev_status,
  input  wire [7:0]  first_key,
  input  wire [7:0]  tick_count,
  input  wire [7:0]  scan_count,
  input  wire [7:0]  fail_count,
  input  wire [47:0] key_detect,
  input  wire [47:0] key_error,
  output reg  [5:0]  key_sel_reg,
  input  wire [15:0] key_signal,
  input  wire [15:0] key_ref,
  input  wire [7:0]  normalized_detect_integrator,
  input  wire        key_gain_test_fail,
  input  wire        key_in_detect,
  input  wire        ref_below_lower_signal_limit,
  input  wire        key_calibrating,
  input  wire        key_cal_failed,
  // Setups memory
  output reg  [8:0]  setup_addr_reg,
  input  wire [7:0]  setup_data,
  // Scan control
  input  wire        scan_end,
  input  wire        key_activity,
  input  wire        wake_int,
  input  wire        slot_strobe,
  input  wire [5:0]  slot_key,
  output reg         scan_halt_reg,
  output reg         asleep_reg,
  output reg         sleep_armed_reg,
  output reg         cal_start_reg,
  output reg  [5:0]  cal_key_reg
);

  // --------------------------------------------------------------------
  // States
  // --------------------------------------------------------------------
  localparam [1:0] S_IDLE = 2'b00;
  localparam [1:0] S_READ = 2'b01;
  localparam [1:0] S_LOAD = 2'b10;
  localparam [1:0] S_WAIT = 2'b11;

  reg  [1:0]  state_reg;
  reg  [2:0]  sck_sync_reg;
  reg  [1:0]  mosi_sync_reg;
  reg  [1:0]  ss_sync_reg;
  reg  [2:0]  wake_sync_reg;
  reg  [2:0]  bit_cnt_reg;
  reg  [6:0]  rx_sh_reg;
  reg  [7:0]  tx_sh_reg;
  reg  [7:0]  hold_reg;
  reg         hold_valid_reg;
  reg  [7:0]  cmd_reg;
  reg  [7:0]  last_cmd_reg;
  reg  [7:0]  last_rep_reg;
  reg  [8:0]  idx_reg;
  reg  [8:0]  len_reg;
  reg         has_crc_reg;
  reg         dump_reg;
  reg         silent_reg;
  reg         cal_first_reg;
  reg         cal_pend_reg;
  reg  [24:0] tmr_reg;
  reg  [7:0]  byte_val;
  reg         d_ok;
  reg         d_crc;
  reg         d_dump;
  reg         d_silent;
  reg  [8:0]  d_len;
  wire [15:0] crc_val;

  // Edges found from the second and third sync stages only
  wire sck_rise  = sck_sync_reg[1] & ~sck_sync_reg[2];
  wire sck_fall  = ~sck_sync_reg[1] & sck_sync_reg[2];
  wire ss_act    = ~ss_sync_reg[1];
  wire wake_rise = wake_sync_reg[1] & ~wake_sync_reg[2];
  wire byte_done = ss_act & sck_rise & (bit_cnt_reg == 3'h7);
  wire [7:0] rx_byte = {rx_sh_reg, mosi_sync_reg[1]};
  // Non-null bytes seen while idle are commands
  wire accept    = byte_done & (state_reg == S_IDLE) & (rx_byte != `TKR_CMD_NULL);
  wire tx_load   = hold_valid_reg & ~data_ready_line_reg & (bit_cnt_reg == 3'h0);
  // One CRC feed per byte taken, not per cycle spent waiting to load
  wire ld_now    = (state_reg == S_LOAD) & (silent_reg | ~hold_valid_reg | tx_load);
  wire tmo_hit   = (tmr_reg >= TMO_CYCLES);
  wire [8:0] total = len_reg + (has_crc_reg ? 9'h002 : 9'h000);
  wire [8:0] idx_inc = idx_reg + 9'h001;
  wire in_data   = (idx_reg < len_reg);

  // --------------------------------------------------------------------
  // Command decode; an unknown code gives no reply
  // --------------------------------------------------------------------
  always @* begin
    d_ok = 1'b0;
    d_crc = 1'b0;
    d_dump = 1'b0;
    d_silent = 1'b0;
    d_len = `TKR_LEN_ONE;
    case (rx_byte)
      `TKR_CMD_OVERVIEW: begin
        d_ok = 1'b1; d_crc = 1'b1; d_len = `TKR_LEN_OVERVIEW;
      end
      `TKR_CMD_KEYS, `TKR_CMD_ERRORS: begin
        d_ok = 1'b1; d_crc = 1'b1; d_len = `TKR_LEN_FIELDS;
      end
      `TKR_CMD_DUMP: begin
        d_ok = 1'b1; d_crc = 1'b1; d_dump = 1'b1; d_len = `TKR_LEN_SETUPS;
      end
      `TKR_CMD_EECRC: begin
        d_ok = 1'b1; d_crc = 1'b1; d_silent = 1'b1; d_len = `TKR_LEN_SETUPS;
      end
      `TKR_CMD_LAST, `TKR_CMD_SLEEP:
        d_ok = 1'b1;
      `TKR_CMD_DIAG_A, `TKR_CMD_DIAG_B: begin
        d_ok = 1'b1; d_crc = 1'b1;
      end
      default: begin
        if (rx_byte[7:6] != 2'b00 && rx_byte[5:0] <= `TKR_KEY_MAX) begin
          case (rx_byte[7:6])
            `TKR_CLS_DATA: begin
              d_ok = 1'b1; d_crc = 1'b1; d_len = `TKR_LEN_KDATA;
            end
            `TKR_CLS_STAT: begin
              d_ok = 1'b1; d_crc = 1'b1;
            end
            default:
              // Second identical request in time schedules it
              d_ok = cal_first_reg & (rx_byte == last_cmd_reg) & ~tmo_hit;
          endcase
        end
      end
    endcase
  end

  // --------------------------------------------------------------------
  // Reply byte for the current index; CRC words go low byte first
  // --------------------------------------------------------------------
  always @* begin
    byte_val = 8'h00;
    if (!in_data)
      byte_val = (idx_reg == len_reg) ? crc_val[7:0] : crc_val[15:8];
    else begin
      case (cmd_reg)
        `TKR_CMD_OVERVIEW: begin
          case (idx_reg[2:0])
            3'h0:    byte_val = dev_status;
            3'h1:    byte_val = first_key;
            3'h2:    byte_val = tick_count;
            3'h3:    byte_val = scan_count;
            default: byte_val = fail_count;
          endcase
        end
        `TKR_CMD_KEYS:   byte_val = key_detect[{idx_reg[2:0], 3'b000} +: 8];
        `TKR_CMD_ERRORS: byte_val = key_error[{idx_reg[2:0], 3'b000} +: 8];
        `TKR_CMD_DUMP, `TKR_CMD_EECRC: byte_val = setup_data;
        `TKR_CMD_LAST:   byte_val = last_rep_reg;
        `TKR_CMD_DIAG_A, `TKR_CMD_DIAG_B: byte_val = `TKR_DIAG_CODE;
        default: begin
          case (cmd_reg[7:6])
            `TKR_CLS_DATA: begin
              case (idx_reg[2:0])
                3'h0:    byte_val = key_signal[7:0];
                3'h1:    byte_val = key_signal[15:8];
                3'h2:    byte_val = key_ref[7:0];
                3'h3:    byte_val = key_ref[15:8];
                default: byte_val = normalized_detect_integrator;
              endcase
            end
            `TKR_CLS_STAT:
              byte_val = {`TKR_STAT_RSVD, key_gain_test_fail, key_in_detect,
                          ref_below_lower_signal_limit, key_calibrating, key_cal_failed};
            default:
              byte_val = ~cmd_reg;
          endcase
        end
      endcase
    end
  end

  // CRC seeded by the command, except setups-only CRCs
  tkr_crc16 u_crc (
    .clk     (clk),
    .reset_n (reset_n),
    .init    (accept),
    .feed    ((accept & d_ok & ~d_dump & ~d_silent) | (ld_now & in_data)),
    .data    (accept ? rx_byte : byte_val),
    .crc_reg (crc_val)
  );

  // --------------------------------------------------------------------
  // Pin synchronisers and SPI shifter (mode 0, MSB first)
  // --------------------------------------------------------------------
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sck_sync_reg <= 3'h0;
      mosi_sync_reg <= 2'h0;
      ss_sync_reg <= 2'h3;
      wake_sync_reg <= 3'h0;
      bit_cnt_reg <= 3'h0;
      rx_sh_reg <= 7'h00;
      tx_sh_reg <= 8'h00;
      spi_miso_reg <= 1'b0;
      data_ready_line_reg <= 1'b0;
    end else begin
      sck_sync_reg <= {sck_sync_reg[1:0], spi_sck};
      mosi_sync_reg <= {mosi_sync_reg[0], spi_mosi};
      ss_sync_reg <= {ss_sync_reg[0], spi_ss_n};
      wake_sync_reg <= {wake_sync_reg[1:0], wake_int};
      if (!ss_act)
        bit_cnt_reg <= 3'h0;
      else if (sck_rise) begin
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
        rx_sh_reg <= rx_byte[6:0];
      end
      // A null is shifted out unless a reply byte was loaded
      if (tx_load) begin
        tx_sh_reg <= hold_reg;
        spi_miso_reg <= hold_reg[7];
        data_ready_line_reg <= 1'b1;
      end else if (byte_done) begin
        tx_sh_reg <= 8'h00;
        spi_miso_reg <= 1'b0;
        data_ready_line_reg <= 1'b0;
      end else if (ss_act && sck_fall && bit_cnt_reg != 3'h0) begin
        tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
        spi_miso_reg <= tx_sh_reg[6];
      end
    end
  end

  // --------------------------------------------------------------------
  // Reply sequencer, timers, sleep and calibration
  // --------------------------------------------------------------------
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= S_IDLE;
      hold_reg <= 8'h00;
      hold_valid_reg <= 1'b0;
      cmd_reg <= 8'h00;
      last_cmd_reg <= 8'h00;
      last_rep_reg <= 8'h00;
      idx_reg <= 9'h000;
      len_reg <= 9'h000;
      has_crc_reg <= 1'b0;
      dump_reg <= 1'b0;
      silent_reg <= 1'b0;
      cal_first_reg <= 1'b0;
      cal_pend_reg <= 1'b0;
      cal_key_reg <= 6'h00;
      cal_start_reg <= 1'b0;
      tmr_reg <= 25'h0000000;
      key_sel_reg <= 6'h00;
      setup_addr_reg <= 9'h000;
      scan_halt_reg <= 1'b0;
      asleep_reg <= 1'b0;
      sleep_armed_reg <= 1'b0;
    end else begin
      cal_start_reg <= 1'b0;
      // Timer restarts per command; in UART mode also per dump byte sent
      if (accept || (uart_mode && dump_reg && tx_load))
        tmr_reg <= 25'h0000000;
      else if (!tmo_hit)
        tmr_reg <= tmr_reg + 25'h0000001;
      if (tx_load)
        hold_valid_reg <= 1'b0;
      if (accept) begin
        last_cmd_reg <= rx_byte;
        last_rep_reg <= ~last_cmd_reg;
        cal_first_reg <= (rx_byte[7:6] == `TKR_CLS_CAL) & ~d_ok;
        cmd_reg <= rx_byte;
        key_sel_reg <= rx_byte[5:0];
        idx_reg <= 9'h000;
        len_reg <= d_len;
        has_crc_reg <= d_crc;
        dump_reg <= d_dump;
        silent_reg <= d_silent;
        setup_addr_reg <= 9'h000;
        if (d_ok) begin
          state_reg <= (d_dump || d_silent) ? S_READ : S_LOAD;
          scan_halt_reg <= d_dump;
          sleep_armed_reg <= (rx_byte == `TKR_CMD_SLEEP);
          if (rx_byte != `TKR_CMD_SLEEP)
            asleep_reg <= 1'b0;
          if (rx_byte[7:6] == `TKR_CLS_CAL && rx_byte[5:0] <= `TKR_KEY_MAX) begin
            cal_pend_reg <= 1'b1;
            cal_key_reg <= rx_byte[5:0];
          end
        end
      end else if (dump_reg && uart_mode && state_reg != S_IDLE && tmo_hit) begin
        // Stalled host: abort, resume scanning
        state_reg <= S_IDLE;
        hold_valid_reg <= 1'b0;
        scan_halt_reg <= 1'b0;
        dump_reg <= 1'b0;
      end else begin
        case (state_reg)
          S_IDLE: state_reg <= S_IDLE;
          S_READ: state_reg <= S_LOAD;
          S_LOAD: begin
            if (silent_reg && in_data)
              state_reg <= S_WAIT;
            else if (!hold_valid_reg || tx_load) begin
              hold_reg <= byte_val;
              hold_valid_reg <= 1'b1;
              state_reg <= S_WAIT;
            end
          end
          default: begin
            if (!hold_valid_reg) begin
              idx_reg <= idx_inc;
              setup_addr_reg <= idx_inc;
              if (idx_inc == total) begin
                state_reg <= S_IDLE;
                scan_halt_reg <= 1'b0;
                dump_reg <= 1'b0;
              end else
                state_reg <= ((dump_reg || silent_reg) && idx_inc < len_reg) ? S_READ : S_LOAD;
            end
          end
        endcase
      end
      // Calibration waits for the key's own timeslot
      if (cal_pend_reg && slot_strobe && slot_key == cal_key_reg && !accept) begin
        cal_pend_reg <= 1'b0;
        cal_start_reg <= 1'b1;
      end
      // Sleep only at scan end with no activity; wake scans then resleeps
      if (!accept) begin
        if (asleep_reg && wake_rise)
          asleep_reg <= 1'b0;
        else if (scan_end && sleep_armed_reg && sleep_enable && !key_activity)
          asleep_reg <= 1'b1;
      end
    end
  end

endmodule

/* File: testbench/tb.sv */
/*
  Self-checking responder bench.
  Assumes the host model and bound checker.
*/
`timescale 1ns/1ps
`include "tkr_consts.vh"

module tb;
  reg         clk, reset_n, uart_mode, sleep_enable, scan_end, key_activity, wake_int;
  reg         slot_strobe;
  reg  [5:0]  slot_key;
  reg  [7:0]  dev_status, first_key, tick_count, scan_count, fail_count, setup_data;
  reg  [47:0] key_detect, key_error;
  reg  [15:0] key_signal, key_ref;
  reg  [7:0]  normalized_detect_integrator;
  reg  [4:0]  kflags;
  wire        spi_sck, spi_mosi, spi_ss_n, spi_miso_reg, data_ready_line_reg;
  wire        scan_halt_reg, asleep_reg, sleep_armed_reg, cal_start_reg;
  wire [5:0]  key_sel_reg, cal_key_reg;
  wire [8:0]  setup_addr_reg;
  reg  [7:0]  rx [0:349];
  reg  [15:0] e;
  reg         halt_mid;
  integer     err_total, total_checks, cal_hits, i;

  tkr_responder #(.TMO_CYCLES(25'h00007D0)) tkr_responder_inst (
    .clk, .reset_n, .spi_sck, .spi_mosi, .spi_ss_n, .spi_miso_reg, .data_ready_line_reg,
    .uart_mode, .sleep_enable, .dev_status, .first_key, .tick_count, .scan_count,
    .fail_count, .key_detect, .key_error, .key_sel_reg, .key_signal, .key_ref,
    .normalized_detect_integrator, .key_gain_test_fail(kflags[4]),
    .key_in_detect(kflags[3]), .ref_below_lower_signal_limit(kflags[2]),
    .key_calibrating(kflags[1]), .key_cal_failed(kflags[0]), .setup_addr_reg,
    .setup_data, .scan_end, .key_activity, .wake_int, .slot_strobe, .slot_key,
    .scan_halt_reg, .asleep_reg, .sleep_armed_reg, .cal_start_reg, .cal_key_reg);
  tkr_host_model tkr_host_model_inst (.clk, .spi_sck, .spi_mosi, .spi_ss_n, .spi_miso_reg,
    .data_ready_line_reg);

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Setups memory, one cycle latency
  function [7:0] smem(input [8:0] a);
    smem = a[7:0] ^ {7'h00, a[8]} ^ 8'h3C;
  endfunction
  always @(posedge clk) setup_data <= smem(setup_addr_reg);
  // Calibration starts counted; timing is the checker's job
  always @(posedge clk) if (cal_start_reg === 1'b1) cal_hits <= cal_hits + 1;

  function [15:0] crc_step(input [15:0] c, input [7:0] d);
    integer k;
    begin
      crc_step = c ^ {d, 8'h00};
      for (k = 0; k < 8; k = k + 1)
        crc_step = crc_step[15] ? (crc_step << 1) ^ `TKR_CRC_POLY : crc_step << 1;
    end
  endfunction

  task chk(input [47:0] got, input [47:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  // Command, then n reply bytes
  task cmd(input [7:0] c, input integer n);
    integer j;
    begin
      tkr_host_model_inst.xfer(c, rx[0]);
      for (j = 0; j < n; j = j + 1) begin
        tkr_host_model_inst.fetch(rx[j]);
        if (j == 1) halt_mid = scan_halt_reg;
      end
    end
  endtask

  // CRC of command and n bytes, low first
  task crc_chk(input [7:0] c, input integer n);
    begin
      e = crc_step(`TKR_CRC_INIT, c);
      for (i = 0; i < n; i = i + 1) e = crc_step(e, rx[i]);
      chk({rx[n+1], rx[n]}, e);
    end
  endtask

  // A refused byte must never load a reply
  task silent(input [7:0] c);
    begin
      tkr_host_model_inst.xfer(c, rx[0]);
      repeat (40) @(posedge clk);
      chk(data_ready_line_reg, 1'b0);
    end
  endtask

  task scan_pulse(input act, input en);
    begin
      @(posedge clk);
      {key_activity, sleep_enable, scan_end} <= {act, en, 1'b1};
      @(posedge clk);
      scan_end <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask

  task t_reports;
    begin
      cmd(`TKR_CMD_OVERVIEW, 7);
      chk({rx[0], rx[1], rx[2], rx[3], rx[4]},
          {dev_status, first_key, tick_count, scan_count, fail_count});
      crc_chk(`TKR_CMD_OVERVIEW, 5);
      cmd(`TKR_CMD_KEYS, 8);
      chk({rx[5], rx[4], rx[3], rx[2], rx[1], rx[0]}, key_detect);
      crc_chk(`TKR_CMD_KEYS, 6);
      tkr_host_model_inst.pause = 3000;
      cmd(`TKR_CMD_ERRORS, 8);
      tkr_host_model_inst.pause = 0;
      chk({rx[5], rx[4], rx[3], rx[2], rx[1], rx[0]}, key_error);
      crc_chk(`TKR_CMD_ERRORS, 6);
      cmd(8'h6F, 7);
      chk({rx[3], rx[2], rx[1], rx[0], rx[4]},
          {key_ref, key_signal, normalized_detect_integrator});
      chk(key_sel_reg, 6'h2F);
      crc_chk(8'h6F, 5);
      cmd(8'hAF, 3);
      chk(rx[0], {3'h0, kflags});
      crc_chk(8'hAF, 1);
      $display("report tests finished");
    end
  endtask

  task t_refuse_cal;
    begin
      silent(8'h70);
      silent(8'hB0);
      silent(8'h05);
      cmd(`TKR_CMD_LAST, 1);
      chk(rx[0], 8'hFA);
      silent(8'hC3);
      cmd(8'hC3, 1);
      chk(rx[0], 8'h3C);
      @(posedge clk);
      {slot_strobe, slot_key} <= {1'b1, 6'h02};
      @(posedge clk);
      {slot_strobe, slot_key} <= {1'b1, 6'h03};
      @(posedge clk);
      slot_strobe <= 1'b0;
      repeat (4) @(posedge clk);
      chk({cal_hits, cal_key_reg}, {32'h1, 6'h03});
      silent(8'hC5);
      cmd(`TKR_CMD_LAST, 1);
      chk(rx[0], 8'h3A);
      silent(8'hC5);
      $display("calibration tests finished");
    end
  endtask

  task t_sleep;
    begin
      cmd(`TKR_CMD_SLEEP, 1);
      chk(rx[0], 8'hE9);
      scan_pulse(1'b1, 1'b1);
      chk(asleep_reg, 1'b0);
      scan_pulse(1'b0, 1'b1);
      chk(asleep_reg, 1'b1);
      wake_int <= 1'b1;
      repeat (10) @(posedge clk);
      wake_int <= 1'b0;
      chk(asleep_reg, 1'b0);
      scan_pulse(1'b0, 1'b1);
      chk(asleep_reg, 1'b1);
      cmd(`TKR_CMD_DIAG_A, 3);
      chk({rx[0], asleep_reg, sleep_armed_reg}, {`TKR_DIAG_CODE, 2'b00});
      crc_chk(`TKR_CMD_DIAG_A, 1);
      cmd(`TKR_CMD_DIAG_B, 3);
      chk(rx[0], `TKR_DIAG_CODE);
      crc_chk(`TKR_CMD_DIAG_B, 1);
      cmd(`TKR_CMD_SLEEP, 1);
      scan_pulse(1'b0, 1'b0);
      chk(asleep_reg, 1'b0);
      $display("sleep tests finished");
    end
  endtask

  task t_setups;
    begin
      e = `TKR_CRC_INIT;
      for (i = 0; i < 348; i = i + 1) e = crc_step(e, smem(i));
      cmd(`TKR_CMD_EECRC, 2);
      chk({rx[1], rx[0]}, e);
      cmd(`TKR_CMD_DUMP, 350);
      for (i = 0; i < 348; i = i + 1) chk(rx[i], smem(i));
      chk({rx[349], rx[348], halt_mid, scan_halt_reg}, {e, 2'b10});
      @(posedge clk) uart_mode <= 1'b1;
      cmd(`TKR_CMD_DUMP, 3);
      repeat (2100) @(posedge clk);
      chk({halt_mid, scan_halt_reg}, 2'b10);
      uart_mode <= 1'b0;
      $display("setups tests finished");
    end
  endtask

  task summarize;
    begin
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask

  // Main sequence; link traffic starts four edges after reset
  initial begin
    {err_total, total_checks, cal_hits} = {32'h0, 32'h0, 32'h0};
    {reset_n, uart_mode, sleep_enable, scan_end, key_activity, wake_int} = 6'h04;
    {slot_strobe, slot_key, kflags} = {1'b0, 6'h00, 5'h15};
    {dev_status, first_key, tick_count, scan_count, fail_count} = 40'h812A13C405;
    {key_detect, key_error} = {48'h800000A50001, 48'h0102040810FF};
    {key_signal, key_ref, normalized_detect_integrator} = 40'h1234ABCD7E;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_reports;
    t_refuse_cal;
    t_sleep;
    t_setups;
    summarize;
  end

  // Hang guard, well past the expected run
  initial begin
    #500000;
    err_total = err_total + 1;
    summarize;
  end
endmodule

/* File: testbench/tkr_host_model.sv */
/*
  Host SPI master model, mode 0: command byte, then one null per reply byte.
  Assumes clk only paces polling; pin changes never fall on a rising clk edge.
*/
`timescale 1ns/1ps

module tkr_host_model (
  // Polling clock
  input  wire clk,
  // Link pins
  output reg  spi_sck,
  output reg  spi_mosi,
  output reg  spi_ss_n,
  input  wire spi_miso_reg,
  input  wire data_ready_line_reg
);
  integer pause;

  initial begin
    spi_sck  = 1'b0;
    spi_mosi = 1'b0;
    spi_ss_n = 1'b1;
    pause    = 0;
  end

  // One byte MSB first; miso taken at sck rise
  task xfer(input [7:0] tx, output [7:0] rx);
    integer i;
    begin
      @(negedge clk);
      spi_ss_n = 1'b0;
      #64;
      for (i = 7; i >= 0; i = i - 1) begin
        spi_mosi = tx[i];
        #32;
        spi_sck = 1'b1;
        rx[i]   = spi_miso_reg;
        #32;
        spi_sck = 1'b0;
      end
      #32;
      // Released line shows the inverse
      spi_mosi = ~spi_mosi;
      spi_ss_n = 1'b1;
      #64;
    end
  endtask

  // Wait for a loaded byte, dawdle, clock a null
  task fetch(output [7:0] rx);
    integer w;
    begin
      w = 0;
      while (data_ready_line_reg !== 1'b1 && w < 2000) begin
        @(negedge clk);
        w = w + 1;
      end
      #(pause);
      xfer(8'h00, rx);
    end
  endtask
endmodule

/* File: testbench/tkr_responder_asserts.sv */
/*
  Responder checker: sleep, wake and calibration timing.
  Assumes it is bound to tkr_responder and sees only its ports.
*/
`timescale 1ns/1ps
`include "tkr_consts.vh"

module tkr_responder_asserts #(
  parameter [24:0] TMO_CYCLES = `TKR_TMO_CYCLES
) (
  // Clock and reset
  input wire       clk,
  input wire       reset_n,
  // Link status
  input wire       data_ready_line_reg,
  input wire       spi_miso_reg,
  // Scan and sleep
  input wire       sleep_enable,
  input wire       scan_end,
  input wire       key_activity,
  input wire       wake_int,
  input wire       scan_halt_reg,
  input wire       asleep_reg,
  input wire       sleep_armed_reg,
  // Calibration
  input wire       slot_strobe,
  input wire [5:0] slot_key,
  input wire       cal_start_reg,
  input wire [5:0] cal_key_reg
);
  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  // Qualifying scan end
  wire sleep_ok = scan_end & sleep_enable & ~key_activity & sleep_armed_reg;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  property p_cal_cause; cal_start_reg |-> $past(slot_strobe) && $past(slot_key) == cal_key_reg; endproperty
  property p_cal_pulse; cal_start_reg |=> !cal_start_reg; endproperty
  property p_sleep_entry; sleep_ok && !asleep_reg |=> asleep_reg; endproperty
  property p_sleep_cause; $rose(asleep_reg) |-> $past(sleep_ok); endproperty
  property p_asleep_armed; asleep_reg |-> sleep_armed_reg; endproperty
  property p_wake; asleep_reg && $rose(wake_int) |-> ##[1:4] !asleep_reg; endproperty
  property p_wake_only; $fell(asleep_reg) && sleep_armed_reg |-> $past(wake_int, 2); endproperty
  property p_halt_awake; scan_halt_reg |-> !sleep_armed_reg && !asleep_reg; endproperty
  property p_sleep_ack; $rose(sleep_armed_reg) |-> ##[0:12] data_ready_line_reg && spi_miso_reg; endproperty

  a_cal_cause: assert property (p_cal_cause)
    else $error("cal outside key slot");
  a_cal_pulse: assert property (p_cal_pulse)
    else $error("cal start too long");
  a_sleep_entry: assert property (p_sleep_entry)
    else $error("no sleep entry");
  a_sleep_cause: assert property (p_sleep_cause)
    else $error("sleep without cause");
  a_asleep_armed: assert property (p_asleep_armed)
    else $error("asleep, not armed");
  a_wake: assert property (p_wake)
    else $error("no wake");
  a_wake_only: assert property (p_wake_only)
    else $error("spurious wake");
  a_halt_awake: assert property (p_halt_awake)
    else $error("sleep during dump");
  a_sleep_ack: assert property (p_sleep_ack)
    else $error("sleep ack late");

  c_cal: cover property (cal_start_reg);
  c_sleep: cover property ($rose(asleep_reg));
  c_dump: cover property ($fell(scan_halt_reg));
endmodule

bind tkr_responder tkr_responder_asserts #(.TMO_CYCLES(TMO_CYCLES)) tkr_responder_asserts_inst (
  .clk(clk), .reset_n(reset_n), .data_ready_line_reg(data_ready_line_reg),
  .spi_miso_reg(spi_miso_reg), .sleep_enable(sleep_enable), .scan_end(scan_end),
  .key_activity(key_activity), .wake_int(wake_int), .scan_halt_reg(scan_halt_reg),
  .asleep_reg(asleep_reg), .sleep_armed_reg(sleep_armed_reg), .slot_strobe(slot_strobe),
  .slot_key(slot_key), .cal_start_reg(cal_start_reg), .cal_key_reg(cal_key_reg));
